// File: verilog/plld_pkg.sv
// shared constants for the lock detect and tuning mode ends
package plld_pkg;

  // ************************************************************
  // field widths and reset values
  // ************************************************************
  localparam int TSPEED_W    = 2;
  localparam int WDIV_W      = 3;
  localparam int THR_W       = 3;
  localparam int OSEL_W      = 5;
  localparam int ODIV_W      = 6;
  localparam int CPOFF_W     = 9;
  localparam int NINT_W      = 19;
  localparam int NFRAC_W     = 24;
  localparam int WIN_W       = 12;
  localparam int RD_W        = 8;
  localparam int RD_CNT_W    = 4;
  localparam int LOCK_BIT    = 1;

  localparam logic [OSEL_W-1:0] OSEL_LOCK    = 5'h01;
  localparam logic [OSEL_W-1:0] OSEL_RST     = 5'h00;
  localparam logic [THR_W-1:0]  THR_RST      = 3'h0;
  localparam logic [THR_W-1:0]  CNT_MAX      = 3'h7;
  localparam logic [ODIV_W-1:0] ODIV_FUND    = 6'h01;
  localparam logic [ODIV_W-1:0] ODIV_MIN     = 6'h02;
  localparam logic [ODIV_W-1:0] ODIV_MAX     = 6'h3E;
  localparam logic [RD_CNT_W-1:0] RD_LEN     = 4'h8;

  // host read timing: phase at which the first data bit is sampled, and the last
  localparam logic [RD_CNT_W-1:0] PH_FIRST   = 4'h3;
  localparam logic [RD_CNT_W-1:0] PH_LAST    = 4'hA;

  // ************************************************************
  // window sizes in tenths of a nanosecond, [speed][divide]
  // ************************************************************
  localparam logic [WIN_W-1:0] ANALOG_WIN_TENTHS = 12'h064;
  localparam logic [0:3][0:7][WIN_W-1:0] WIN_TABLE = '{
    '{12'h041, 12'h050, 12'h06E, 12'h0AA, 12'h122, 12'h212, 12'h3E8, 12'h79E},
    '{12'h046, 12'h059, 12'h080, 12'h0D2, 12'h168, 12'h2A8, 12'h514, 12'h9F6},
    '{12'h047, 12'h05C, 12'h085, 12'h0DC, 12'h17C, 12'h2D0, 12'h564, 12'hAA0},
    '{12'h04C, 12'h066, 12'h09A, 12'h104, 12'h1D6, 12'h370, 12'h6B8, 12'hD34}
  };

  function automatic logic [WIN_W-1:0] win_tenths(input logic [TSPEED_W-1:0] sp,
                                                  input logic [WDIV_W-1:0]   dv);
    win_tenths = WIN_TABLE[sp][dv];
  endfunction : win_tenths

endpackage : plld_pkg

// File: verilog/plld_if.sv
// configuration wires and the shared lock or serial out pin between host and device
`timescale 1ns/100ps
interface plld_if;
  logic                           det_enable;
  logic                           det_digital;
  logic [plld_pkg::TSPEED_W-1:0]  window_timer_speed;
  logic [plld_pkg::WDIV_W-1:0]    window_divide_code;
  logic [plld_pkg::THR_W-1:0]     lock_threshold;
  logic [plld_pkg::OSEL_W-1:0]    out_select;
  logic                           lock_always;
  logic [plld_pkg::ODIV_W-1:0]    out_divider;
  logic                           frac_enable;
  logic                           mod_bypass;
  logic [plld_pkg::CPOFF_W-1:0]   charge_pump_offset;
  logic                           rd_req;
  logic                           lock_or_serial_out_pin;

  modport dev (
    input  det_enable,
    input  det_digital,
    input  window_timer_speed,
    input  window_divide_code,
    input  lock_threshold,
    input  out_select,
    input  lock_always,
    input  out_divider,
    input  frac_enable,
    input  mod_bypass,
    input  charge_pump_offset,
    input  rd_req,
    output lock_or_serial_out_pin
  );

  modport hst (
    output det_enable,
    output det_digital,
    output window_timer_speed,
    output window_divide_code,
    output lock_threshold,
    output out_select,
    output lock_always,
    output out_divider,
    output frac_enable,
    output mod_bypass,
    output charge_pump_offset,
    output rd_req,
    input  lock_or_serial_out_pin
  );
endinterface : plld_if

// File: verilog/plld_dev.sv
// device end: lock detector, lock or serial out pin and tuning mode outputs
//
// What the document requires
// R1: host picks analog detect only at 10 ns
// R2: window from speed and divide codes
// R3: divide code roughly doubles window per step
// R4: host programs nearest tabulated window entry
// R5: required window from rate and currents; the host takes req_window_tenths as given and computes nothing
// R6: host recomputes window after large changes
// R7: output select one shows lock on pin
// R8: serial read temporarily replaces lock flag
// R9: lock always bit suppresses serial read
// R10: host sets even divider below fundamental band
// R11: integer mode: modulator off, bypass on
// R12: integer mode steps equal comparison frequency
// R13: host clears charge pump offset in integer
// R14: detector works only when enabled
// R15: in window hits count up to threshold
// R16: one miss clears count, reports unlock
// R17: status bit reads one when locked
`timescale 1ns/100ps
module plld_dev #(
  parameter int GAP_W = 16
) (
  input  wire logic                           mclk,
  input  wire logic                           sys_rst,
  plld_if.dev                                 lnk,
  input  wire logic                           cmp_valid,
  input  wire logic [GAP_W-1:0]               edge_gap_tenths,
  input  wire logic [plld_pkg::NINT_W-1:0]    n_int,
  input  wire logic [plld_pkg::NFRAC_W-1:0]   n_frac,
  output logic                                lock_indicator,
  output logic                                in_window,
  output logic [plld_pkg::WIN_W-1:0]          window_tenths,
  output logic                                integer_mode,
  output logic [plld_pkg::NINT_W-1:0]         eff_int,
  output logic [plld_pkg::NFRAC_W-1:0]        eff_frac,
  output logic [plld_pkg::ODIV_W-1:0]         out_ratio,
  output logic                                read_blocked
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (GAP_W < plld_pkg::WIN_W) begin : g_bad_gap
    $error("edge gap narrower than window width");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [plld_pkg::THR_W-1:0]     cnt;
    logic                           locked;
    logic                           hit;
    logic [plld_pkg::WIN_W-1:0]     win;
    logic [plld_pkg::RD_W-1:0]      sh;
    logic [plld_pkg::RD_CNT_W-1:0]  rd_cnt;
    logic                           pin;
    logic                           int_mode;
    logic [plld_pkg::NINT_W-1:0]    nint;
    logic [plld_pkg::NFRAC_W-1:0]   nfrac;
    logic [plld_pkg::ODIV_W-1:0]    odiv;
    logic                           blocked;
  } plld_dev_s;

  plld_dev_s st_r;
  plld_dev_s st_nxt;

  logic [plld_pkg::WIN_W-1:0]    win_sel;
  logic [plld_pkg::THR_W-1:0]    cnt_inc;
  logic [plld_pkg::RD_W-1:0]     status_word;
  logic                          gap_ok;
  logic                          reading;

  // ************************************************************
  // window selection and comparison
  // ************************************************************
  always_comb begin
    // digital windows come from the table, analog is fixed
    if (lnk.det_digital) begin
      win_sel = plld_pkg::win_tenths(lnk.window_timer_speed,
                                     lnk.window_divide_code); // R2 R3
    end else begin
      win_sel = plld_pkg::ANALOG_WIN_TENTHS;
    end
    gap_ok = (edge_gap_tenths <= GAP_W'(win_sel));
    // saturating count so the lock holds beyond the threshold
    if (st_r.cnt == plld_pkg::CNT_MAX) begin
      cnt_inc = st_r.cnt;
    end else begin
      cnt_inc = st_r.cnt + 3'h1;
    end
    status_word = '0;
    status_word[plld_pkg::LOCK_BIT] = st_r.locked; // R17
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.hit = 1'b0;
    st_nxt.win = win_sel;

    // lock detector
    if (!lnk.det_enable) begin
      st_nxt.cnt    = '0; // R14
      st_nxt.locked = 1'b0; // R14
    end else if (cmp_valid) begin
      if (gap_ok) begin
        st_nxt.hit = 1'b1;
        st_nxt.cnt = cnt_inc; // R15
        if (cnt_inc >= lnk.lock_threshold) begin
          st_nxt.locked = 1'b1; // R15
        end
      end else begin
        st_nxt.cnt    = '0; // R16
        st_nxt.locked = 1'b0; // R16
      end
    end

    // serial read of the status word, refused while lock is forced
    st_nxt.blocked = lnk.lock_always; // R9
    if (lnk.rd_req && !lnk.lock_always && (st_r.rd_cnt == '0)) begin
      st_nxt.sh     = status_word;
      st_nxt.rd_cnt = plld_pkg::RD_LEN;
    end else if (st_r.rd_cnt != '0) begin
      st_nxt.sh     = {st_r.sh[plld_pkg::RD_W-2:0], 1'b0};
      st_nxt.rd_cnt = st_r.rd_cnt - 4'h1;
    end
    if (lnk.lock_always) begin
      st_nxt.rd_cnt = '0; // R9
    end

    // shared pin
    reading = (st_r.rd_cnt != '0) && !lnk.lock_always;
    if (lnk.lock_always) begin
      st_nxt.pin = st_nxt.locked; // R9
    end else if (reading) begin
      st_nxt.pin = st_r.sh[plld_pkg::RD_W-1]; // R8
    end else if (lnk.out_select == plld_pkg::OSEL_LOCK) begin
      st_nxt.pin = st_nxt.locked; // R7
    end else begin
      st_nxt.pin = 1'b0;
    end

    // tuning mode
    st_nxt.int_mode = !lnk.frac_enable && lnk.mod_bypass;
    st_nxt.nint     = n_int;
    if (st_nxt.int_mode) begin
      st_nxt.nfrac = '0; // R12
    end else begin
      st_nxt.nfrac = n_frac;
    end
    st_nxt.odiv = lnk.out_divider;

    if (sys_rst) begin
      st_nxt.cnt      = '0;
      st_nxt.locked   = 1'b0;
      st_nxt.hit      = 1'b0;
      st_nxt.win      = '0;
      st_nxt.sh       = '0;
      st_nxt.rd_cnt   = '0;
      st_nxt.pin      = 1'b0;
      st_nxt.int_mode = 1'b0;
      st_nxt.nint     = '0;
      st_nxt.nfrac    = '0;
      st_nxt.odiv     = plld_pkg::ODIV_FUND;
      st_nxt.blocked  = 1'b0;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign lnk.lock_or_serial_out_pin = st_r.pin;
  assign lock_indicator             = st_r.locked;
  assign in_window                  = st_r.hit;
  assign window_tenths              = st_r.win;
  assign integer_mode               = st_r.int_mode;
  assign eff_int                    = st_r.nint;
  assign eff_frac                   = st_r.nfrac;
  assign out_ratio                  = st_r.odiv;
  assign read_blocked               = st_r.blocked;

endmodule : plld_dev

// File: verilog/plld_host.sv
// host end: picks window codes and modes, drives config and reads status serially
`timescale 1ns/100ps
module plld_host (
  input  wire logic                           mclk,
  input  wire logic                           sys_rst,
  plld_if.hst                                 lnk,
  input  wire logic [plld_pkg::WIN_W-1:0]     req_window_tenths,
  input  wire logic                           det_enable_req,
  input  wire logic [plld_pkg::THR_W-1:0]     threshold_req,
  input  wire logic [plld_pkg::OSEL_W-1:0]    out_select_req,
  input  wire logic                           lock_always_req,
  input  wire logic                           want_integer,
  input  wire logic [plld_pkg::ODIV_W-1:0]    want_ratio,
  input  wire logic [plld_pkg::CPOFF_W-1:0]   pump_offset_req,
  input  wire logic                           rd_go,
  output logic                                lock_seen,
  output logic [plld_pkg::RD_W-1:0]           rd_data,
  output logic                                rd_done
);

  typedef struct packed {
    logic                           det_en;
    logic                           det_dig;
    logic [plld_pkg::TSPEED_W-1:0]  sp;
    logic [plld_pkg::WDIV_W-1:0]    dv;
    logic [plld_pkg::THR_W-1:0]     thr;
    logic [plld_pkg::OSEL_W-1:0]    osel;
    logic                           lalw;
    logic [plld_pkg::ODIV_W-1:0]    odiv;
    logic                           fen;
    logic                           byp;
    logic [plld_pkg::CPOFF_W-1:0]   cpoff;
    logic                           rq;
    logic [plld_pkg::RD_CNT_W-1:0]  ph;
    logic [plld_pkg::RD_W-1:0]      sh;
    logic [plld_pkg::RD_W-1:0]      data;
    logic                           done;
    logic                           lock;
  } plld_host_s;

  plld_host_s st_r;
  plld_host_s st_nxt;

  // ************************************************************
  // nearest table entry
  // ************************************************************
  function automatic logic [4:0] nearest(input logic [plld_pkg::WIN_W-1:0] want);
    logic [plld_pkg::WIN_W-1:0] best_d;
    logic [plld_pkg::WIN_W-1:0] d;
    logic [plld_pkg::WIN_W-1:0] w;
    best_d  = '1;
    nearest = '0;
    for (int i = 0; i < 32; i++) begin
      w = plld_pkg::win_tenths(i[4:3], i[2:0]);
      d = (w > want) ? (w - want) : (want - w);
      if (d < best_d) begin
        best_d  = d;
        nearest = i[4:0];
      end
    end
  endfunction : nearest

  logic [4:0] pick;

  always_comb begin
    pick   = nearest(req_window_tenths); // R4 R5 R6
    st_nxt = st_r;
    st_nxt.det_en  = det_enable_req;
    st_nxt.det_dig = (req_window_tenths != plld_pkg::ANALOG_WIN_TENTHS); // R1
    st_nxt.sp     = pick[4:3]; // R4
    st_nxt.dv     = pick[2:0]; // R4
    st_nxt.thr    = threshold_req;
    st_nxt.osel   = out_select_req;
    st_nxt.lalw   = lock_always_req;
    // even ratio 2..62 below the fundamental band, fundamental for requests under 2, 62 for requests above 62
    if (want_ratio < plld_pkg::ODIV_MIN) begin
      st_nxt.odiv = plld_pkg::ODIV_FUND; // R10
    end else if (want_ratio > plld_pkg::ODIV_MAX) begin
      st_nxt.odiv = plld_pkg::ODIV_MAX; // R10
    end else begin
      st_nxt.odiv = {want_ratio[plld_pkg::ODIV_W-1:1], 1'b0}; // R10
    end
    st_nxt.fen   = !want_integer; // R11
    st_nxt.byp   = want_integer; // R11
    st_nxt.cpoff = want_integer ? '0 : pump_offset_req; // R13
    st_nxt.rq    = 1'b0;
    st_nxt.done  = 1'b0;
    if (st_r.ph == '0) begin
      st_nxt.lock = lnk.lock_or_serial_out_pin;
      if (rd_go && !st_r.lalw) begin
        st_nxt.rq = 1'b1;
        st_nxt.ph = 4'h1;
      end
    end else begin
      st_nxt.ph = st_r.ph + 4'h1;
      if (st_r.ph >= plld_pkg::PH_FIRST) begin
        st_nxt.sh = {st_r.sh[plld_pkg::RD_W-2:0], lnk.lock_or_serial_out_pin}; // R8
      end
      if (st_r.ph == plld_pkg::PH_LAST) begin
        st_nxt.data = {st_r.sh[plld_pkg::RD_W-2:0], lnk.lock_or_serial_out_pin};
        st_nxt.done = 1'b1;
        st_nxt.ph   = '0;
      end
    end
    if (sys_rst) begin
      st_nxt      = '0;
      st_nxt.osel = plld_pkg::OSEL_RST;
      st_nxt.thr  = plld_pkg::THR_RST;
      st_nxt.odiv = plld_pkg::ODIV_FUND;
      st_nxt.fen  = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  assign lnk.det_enable         = st_r.det_en;
  assign lnk.det_digital        = st_r.det_dig;
  assign lnk.window_timer_speed = st_r.sp;
  assign lnk.window_divide_code = st_r.dv;
  assign lnk.lock_threshold     = st_r.thr;
  assign lnk.out_select         = st_r.osel;
  assign lnk.lock_always        = st_r.lalw;
  assign lnk.out_divider        = st_r.odiv;
  assign lnk.frac_enable        = st_r.fen;
  assign lnk.mod_bypass         = st_r.byp;
  assign lnk.charge_pump_offset = st_r.cpoff;
  assign lnk.rd_req             = st_r.rq;
  assign lock_seen              = st_r.lock;
  assign rd_data                = st_r.data;
  assign rd_done                = st_r.done;

endmodule : plld_host

// File: dv/plld_chk_sva.sv
// assertions on the wires between the host end and the device end
`timescale 1ns/100ps
module plld_chk (
  input wire logic                        mclk,
  input wire logic                        sys_rst,
  input wire logic                        det_enable,
  input wire logic                        lock_always,
  input wire logic [plld_pkg::OSEL_W-1:0] out_select,
  input wire logic [plld_pkg::ODIV_W-1:0] out_divider,
  input wire logic                        frac_enable,
  input wire logic                        mod_bypass,
  input wire logic [plld_pkg::CPOFF_W-1:0] charge_pump_offset,
  input wire logic                        rd_req,
  input wire logic                        lock_or_serial_out_pin
);
  // ************************************************************
  // cycles since the last read request, saturating
  // ************************************************************
  logic [3:0] since_rd_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      since_rd_r <= 4'hF;
    end else if (rd_req) begin
      since_rd_r <= 4'h0;
    end else if (since_rd_r != 4'hF) begin
      since_rd_r <= since_rd_r + 4'h1;
    end
  end

  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // status word: bits 7..2 and bit 0 are always zero
  sequence s_rd_word;
    ##2 (!lock_or_serial_out_pin)[*6] ##2 !lock_or_serial_out_pin;
  endsequence

  sequence s_off;
    (!det_enable && lock_always)[*3];
  endsequence

  property p_rd_word;
    @(posedge mclk) disable iff (sys_rst || lock_always) rd_req |-> s_rd_word;
  endproperty

  a_mode_pair: assert property (frac_enable == !mod_bypass)
    else $error("modulator enable and bypass disagree");
  a_rd_spacing: assert property (rd_req |=> (!rd_req)[*8])
    else $error("read request not a lone pulse");
  a_rd_word: assert property (p_rd_word)
    else $error("serial word bits wrong");
  a_block_no_read: assert property ($past(lock_always) |-> !rd_req)
    else $error("read requested while lock output is forced");
  a_idle_pin_low: assert property (since_rd_r >= 4'hA
      && $past(out_select) != plld_pkg::OSEL_LOCK
      && !$past(lock_always) |-> !lock_or_serial_out_pin)
    else $error("pin active while not selected");
  a_off_pin_low: assert property (s_off |-> !lock_or_serial_out_pin)
    else $error("pin shows lock while detector disabled");
  a_div_legal: assert property (out_divider == plld_pkg::ODIV_FUND || (!out_divider[0]
      && out_divider >= plld_pkg::ODIV_MIN && out_divider <= plld_pkg::ODIV_MAX))
    else $error("output divider code illegal");
  // reset itself is the antecedent, so this one must not be disabled by it
  a_rst_values: assert property (@(posedge mclk) disable iff (1'b0) sys_rst |=> !rd_req
      && frac_enable && out_divider == plld_pkg::ODIV_FUND)
    else $error("host reset values wrong");
  a_int_no_offset: assert property (!frac_enable && mod_bypass |-> charge_pump_offset == '0)
    else $error("charge pump offset left on in integer mode");
endmodule : plld_chk

// File: dv/plld_tb_top.sv
// scenario bench joining host end and device end through the interface
`timescale 1ns/100ps
module plld_tb_top;
  logic                          mclk;
  logic                          sys_rst;
  logic [plld_pkg::WIN_W-1:0]    req_win;
  logic                          det_en_req;
  logic [2:0]                    thr_req;
  logic [4:0]                    osel_req;
  logic                          lalw_req;
  logic                          want_int;
  logic [5:0]                    want_ratio;
  logic [8:0]                    pump_off_req;
  logic                          rd_go;
  logic                          cmp_valid;
  logic [15:0]                   gap;
  logic [18:0]                   n_int;
  logic [23:0]                   n_frac;
  logic                          lock_seen;
  logic [7:0]                    rd_data;
  logic                          rd_done;
  logic                          lock_ind;
  logic                          in_win;
  logic [11:0]                   win_t;
  logic                          int_mode;
  logic [18:0]                   eff_int;
  logic [23:0]                   eff_frac;
  logic [5:0]                    out_ratio;
  logic                          rd_blk;
  int                            n_mismatch;
  int                            total_checks;

  plld_if lnk_if ();
  plld_host plld_host_inst (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk_if.hst),
    .req_window_tenths(req_win), .det_enable_req(det_en_req), .threshold_req(thr_req),
    .out_select_req(osel_req), .lock_always_req(lalw_req), .want_integer(want_int),
    .want_ratio(want_ratio), .pump_offset_req(pump_off_req), .rd_go(rd_go),
    .lock_seen(lock_seen), .rd_data(rd_data), .rd_done(rd_done));
  plld_dev #(.GAP_W(16)) plld_dev_inst (.mclk(mclk), .sys_rst(sys_rst), .lnk(lnk_if.dev),
    .cmp_valid(cmp_valid), .edge_gap_tenths(gap), .n_int(n_int), .n_frac(n_frac),
    .lock_indicator(lock_ind), .in_window(in_win), .window_tenths(win_t),
    .integer_mode(int_mode), .eff_int(eff_int), .eff_frac(eff_frac),
    .out_ratio(out_ratio), .read_blocked(rd_blk));
  plld_chk plld_chk_inst (.mclk(mclk), .sys_rst(sys_rst), .det_enable(lnk_if.det_enable),
    .lock_always(lnk_if.lock_always), .out_select(lnk_if.out_select),
    .out_divider(lnk_if.out_divider), .frac_enable(lnk_if.frac_enable),
    .mod_bypass(lnk_if.mod_bypass), .rd_req(lnk_if.rd_req),
    .charge_pump_offset(lnk_if.charge_pump_offset),
    .lock_or_serial_out_pin(lnk_if.lock_or_serial_out_pin));

  always #10 mclk = ~mclk;

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  task automatic burst(input logic [15:0] g, input int n);
    cmp_valid = 1'b1;
    gap = g;
    tick(n);
    cmp_valid = 1'b0;
  endtask : burst

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_window;
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 8; d++) begin
        req_win = plld_pkg::WIN_TABLE[s][d];
        tick(4);
        chk("window", 24'(plld_pkg::WIN_TABLE[s][d]), 24'(win_t));
        chk("codes", 24'({s[1:0], d[2:0]}),
            24'({lnk_if.window_timer_speed, lnk_if.window_divide_code}));
        chk("digital", 24'h000001, 24'(lnk_if.det_digital));
      end
    end
    req_win = 12'h084;
    tick(4);
    chk("nearest", 24'h000012,
        24'({lnk_if.window_timer_speed, lnk_if.window_divide_code}));
    req_win = plld_pkg::ANALOG_WIN_TENTHS;
    tick(4);
    chk("digital", 24'h000000, 24'(lnk_if.det_digital));
    chk("window", 24'h000064, 24'(win_t));
  endtask : t_window

  task automatic t_lock;
    req_win = 12'h041;
    thr_req = 3'h3;
    det_en_req = 1'b1;
    osel_req = 5'h01;
    tick(4);
    burst(16'h0041, 2);
    chk("lock", 24'h0, 24'(lock_ind));
    chk("hit", 24'h1, 24'(in_win));
    tick(1);
    burst(16'h0000, 1);
    chk("lock", 24'h1, 24'(lock_ind));
    tick(2);
    chk("pin", 24'h1, 24'(lnk_if.lock_or_serial_out_pin));
    chk("lock_seen", 24'h1, 24'(lock_seen));
    burst(16'h0042, 1);
    chk("lock", 24'h0, 24'(lock_ind));
    chk("hit", 24'h0, 24'(in_win));
    tick(2);
    chk("pin", 24'h0, 24'(lnk_if.lock_or_serial_out_pin));
    det_en_req = 1'b0;
    tick(3);
    burst(16'h0000, 5);
    chk("lock", 24'h0, 24'(lock_ind));
    chk("hit", 24'h0, 24'(in_win));
    det_en_req = 1'b1;
    thr_req = 3'h1;
    tick(3);
    burst(16'h0000, 1);
    chk("lock", 24'h1, 24'(lock_ind));
    tick(2);
  endtask : t_lock

  task automatic t_read(input logic [7:0] exp);
    int w;
    rd_go = 1'b1;
    tick(1);
    rd_go = 1'b0;
    w = 0;
    while (rd_done !== 1'b1 && w < 20) begin
      tick(1);
      w++;
    end
    chk("rd_done", 24'h1, 24'(rd_done));
    chk("rd_data", 24'(exp), 24'(rd_data));
    tick(2);
    chk("pin", 24'(exp[1]), 24'(lnk_if.lock_or_serial_out_pin));
  endtask : t_read

  task automatic t_block;
    burst(16'h0000, 1);
    osel_req = 5'h00;
    lalw_req = 1'b1;
    tick(3);
    chk("blocked", 24'h1, 24'(rd_blk));
    chk("pin", 24'h1, 24'(lnk_if.lock_or_serial_out_pin));
    rd_go = 1'b1;
    for (int i = 0; i < 15; i++) begin
      tick(1);
      chk("rd_done", 24'h0, 24'(rd_done));
    end
    rd_go = 1'b0;
    det_en_req = 1'b0;
    tick(5);
    chk("pin", 24'h0, 24'(lnk_if.lock_or_serial_out_pin));
    lalw_req = 1'b0;
    det_en_req = 1'b1;
    tick(3);
  endtask : t_block

  task automatic t_mode;
    n_int = 19'h00038;
    n_frac = 24'h19999A;
    pump_off_req = 9'h150;
    want_int = 1'b1;
    tick(4);
    chk("int_mode", 24'h1, 24'(int_mode));
    chk("mode wires", 24'h1, 24'({lnk_if.frac_enable, lnk_if.mod_bypass}));
    chk("eff_frac", 24'h0, eff_frac);
    chk("eff_int", 24'h38, 24'(eff_int));
    chk("pump offset", 24'h0, 24'(lnk_if.charge_pump_offset));
    want_int = 1'b0;
    tick(4);
    chk("int_mode", 24'h0, 24'(int_mode));
    chk("pump offset", 24'h150, 24'(lnk_if.charge_pump_offset));
    chk("eff_frac", 24'h19999A, eff_frac);
  endtask : t_mode

  task automatic t_ratio;
    logic [5:0] ask [6];
    logic [5:0] want_r [6];
    ask = '{6'h00, 6'h01, 6'h02, 6'h07, 6'h3E, 6'h3F};
    want_r = '{6'h01, 6'h01, 6'h02, 6'h06, 6'h3E, 6'h3E};
    foreach (ask[i]) begin
      want_ratio = ask[i];
      tick(4);
      chk("out_ratio", 24'(want_r[i]), 24'(out_ratio));
    end
  endtask : t_ratio

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    req_win = 12'h041;
    {det_en_req, thr_req, osel_req, lalw_req, want_int, rd_go, cmp_valid} = '0;
    want_ratio = 6'h01;
    pump_off_req = 9'h000;
    gap = 16'h0000;
    n_int = 19'h00000;
    n_frac = 24'h000000;
    n_mismatch = 0;
    total_checks = 0;
    tick(12);
    sys_rst = 1'b0;
    tick(2);
    chk("out_ratio", 24'h1, 24'(out_ratio));
    t_window();
    t_lock();
    t_read(8'h02);
    burst(16'h0FFF, 1);
    t_read(8'h00);
    t_block();
    t_mode();
    t_ratio();
    summarize();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    summarize();
  end
endmodule : plld_tb_top
